/* shared/wdt_pkg.sv */
// constants shared by the default-start watchdog and its counter
// assumes a single 10 MHz aclk domain with AXI4-Lite register access
`default_nettype none
package wdt_pkg;

  // byte addresses of the registers
  localparam logic [31:0] ADDR_MODE = 32'h0fff_f6d0;
  localparam logic [31:0] ADDR_KEY = 32'h0fff_f6d4;
  localparam logic [31:0] ADDR_STATUS = 32'h0fff_f6d8;
  localparam logic [31:0] ADDR_COUNT = 32'h0fff_f6dc;
  localparam logic [31:0] ADDR_BITOP = 32'h0fff_f6e0;

  // mode register fields
  localparam int MODE_HI_BIT = 6;
  localparam int MODE_LO_BIT = 5;
  localparam int SRC_HI_BIT = 4;
  localparam int SRC_LO_BIT = 3;
  localparam int IVL_MSB = 2;
  localparam logic [7:0] MODE_WR_MASK = 8'h7f;

  // reset and key values
  localparam logic [7:0] MODE_RST = 8'h67;
  localparam logic [7:0] KEY_READ = 8'h9a;
  localparam logic [7:0] KEY_VAL = 8'hac;

  // base powers of two of the overflow interval
  localparam logic [4:0] BASE_OSC = 5'h0c;
  localparam logic [4:0] BASE_MAIN = 5'h12;
  localparam logic [4:0] BASE_SUB = 5'h09;

  // widest interval is two to the twenty-fifth
  localparam int CNT_W = 25;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SRC_OSC = 2'b00,
    SRC_MAIN = 2'b01,
    SRC_SUB = 2'b10
  } src_e;

  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_NMI = 2'b01,
    MODE_RESET = 2'b10
  } mode_e;

endpackage : wdt_pkg
`default_nettype wire

/* rtl/wdt_counter.sv */
// overflow counter of the watchdog: counts ticks up to two to the exp
// assumes tick is a one-cycle pulse synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module wdt_counter #(
  parameter int WIDTH = wdt_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic tick,
  input wire logic [4:0] exp,
  output logic [WIDTH-1:0] cnt,
  output logic ovf
);

  logic [WIDTH-1:0] mask;
  logic at_top;

  // bits below the selected power must all be one at the last count
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_mask
      assign mask[i] = (5'(i) < exp);
    end
  endgenerate

  assign at_top = ((cnt & mask) == mask);
  assign ovf = tick && at_top && !clear;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (clear || ovf) begin
      cnt <= '0;
    end else if (tick) begin
      cnt <= cnt + 1'b1;
    end
  end

endmodule : wdt_counter
`default_nettype wire

/* rtl/default_start_watchdog.sv */
// default-start watchdog with write-once mode register and restart key
// assumes count-source ticks are one-cycle pulses synchronous to aclk,
// and that the system reset follows the overflow reset output
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module default_start_watchdog #(
  parameter int CNT_WIDTH = wdt_pkg::CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic osc_tick,
  input wire logic main_tick,
  input wire logic sub_tick,
  input wire logic internal_osc_stop,
  input wire logic osc_stab_active,
  output logic overflow_reset_out,
  output logic overflow_nmi_request,
  output logic cpu_clk_switch_req
);

  // function for decoding the mode field, used by route and status
  function automatic wdt_pkg::mode_e decode_mode(input logic [7:0] m);
    if (m[wdt_pkg::MODE_HI_BIT]) begin
      decode_mode = wdt_pkg::MODE_RESET;
    end else if (m[wdt_pkg::MODE_LO_BIT]) begin
      decode_mode = wdt_pkg::MODE_NMI;
    end else begin
      decode_mode = wdt_pkg::MODE_STOP;
    end
  endfunction : decode_mode

  logic [7:0] mode_reg;
  logic mode_written;
  logic aw_held;
  logic w_held;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [CNT_WIDTH-1:0] cnt;
  logic timer_ovf;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire lane0 = wr_strb[0];

  wire hit_mode = (wr_addr == wdt_pkg::ADDR_MODE);
  wire hit_key = (wr_addr == wdt_pkg::ADDR_KEY);
  wire hit_bitop = (wr_addr == wdt_pkg::ADDR_BITOP);
  wire hit_ro = (wr_addr == wdt_pkg::ADDR_STATUS) ||
                (wr_addr == wdt_pkg::ADDR_COUNT);
  wire wr_mapped = hit_mode || hit_key || hit_bitop || hit_ro;

  // mode and key writes without the low byte lane are dropped as unsupported widths
  wire mode_we = do_write && hit_mode && lane0;
  wire key_we = do_write && hit_key && lane0;
  wire bitop_we = do_write && hit_bitop;
  wire key_ok = key_we && (wr_data[7:0] == wdt_pkg::KEY_VAL);

  wire first_mode_we = mode_we && !mode_written;
  wire force_ovf = (mode_we && mode_written) ||
                   (key_we && !key_ok) ||
                   bitop_we;

  wdt_pkg::mode_e mode_now;
  wdt_pkg::src_e src_now;
  assign mode_now = decode_mode(mode_reg);
  wire running = (mode_now != wdt_pkg::MODE_STOP);
  wire nmi_sel = (mode_now == wdt_pkg::MODE_NMI);

  // the bit below the source msb is ignored once the subclock is picked
  assign src_now = mode_reg[wdt_pkg::SRC_HI_BIT] ? wdt_pkg::SRC_SUB :
                   (mode_reg[wdt_pkg::SRC_LO_BIT] ? wdt_pkg::SRC_MAIN :
                    wdt_pkg::SRC_OSC);

  wire [4:0] base_pow = (src_now == wdt_pkg::SRC_SUB) ? wdt_pkg::BASE_SUB :
                        ((src_now == wdt_pkg::SRC_MAIN) ?
                         wdt_pkg::BASE_MAIN : wdt_pkg::BASE_OSC);
  wire [4:0] exp_now = base_pow +
                       {2'b00, mode_reg[wdt_pkg::IVL_MSB:0]};

  // a stopped oscillator sends no ticks, so the count simply freezes
  wire osc_live = osc_tick && !internal_osc_stop;
  wire src_tick = (src_now == wdt_pkg::SRC_SUB) ? sub_tick :
                  ((src_now == wdt_pkg::SRC_MAIN) ? main_tick : osc_live);
  wire cnt_tick = running && src_tick;

  wire cnt_clear = key_ok ||
                   first_mode_we ||
                   force_ovf;

  wdt_counter #(
    .WIDTH(CNT_WIDTH)
  ) u_counter (
    .clk(aclk),
    .rst_n(aresetn),
    .clear(cnt_clear),
    .tick(cnt_tick),
    .exp(exp_now),
    .cnt(cnt),
    .ovf(timer_ovf)
  );

  wire ovf_evt = timer_ovf || force_ovf;
  // forced overflows in stop mode go out as reset, or as a clock switch request while osc_stab_active is set
  wire to_nmi = ovf_evt && nmi_sel;
  wire to_rst = ovf_evt && !nmi_sel && !osc_stab_active;
  wire to_sw = ovf_evt && !nmi_sel && osc_stab_active;

  // mode register, write-once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= wdt_pkg::MODE_RST;
      mode_written <= 1'b0;
    end else if (first_mode_we) begin
      mode_reg <= wr_data[7:0] & wdt_pkg::MODE_WR_MASK;
      mode_written <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_reset_out <= 1'b0;
      overflow_nmi_request <= 1'b0;
      cpu_clk_switch_req <= 1'b0;
    end else begin
      overflow_reset_out <= to_rst;
      overflow_nmi_request <= to_nmi;
      cpu_clk_switch_req <= to_sw;
    end
  end

  // write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      wr_addr <= 32'h0000_0000;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      wr_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else if (w_take) begin
      w_held <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
    end else if (aw_take) begin
      s_axi_awready <= 1'b0;
    end else if (!aw_held && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
    end else if (w_take) begin
      s_axi_wready <= 1'b0;
    end else if (!w_held && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= wdt_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel
  wire rd_mode = (s_axi_araddr == wdt_pkg::ADDR_MODE);
  wire rd_key = (s_axi_araddr == wdt_pkg::ADDR_KEY);
  wire rd_status = (s_axi_araddr == wdt_pkg::ADDR_STATUS);
  wire rd_count = (s_axi_araddr == wdt_pkg::ADDR_COUNT);
  wire rd_bitop = (s_axi_araddr == wdt_pkg::ADDR_BITOP);
  wire rd_mapped = rd_mode || rd_key || rd_status || rd_count || rd_bitop;
  wire [31:0] status_word = {28'h000_0000, nmi_sel, osc_stab_active,
                             running, mode_written};
  wire [31:0] rd_word =
    rd_mode ? {24'h00_0000, mode_reg} :
    (rd_key || rd_bitop) ? {24'h00_0000, wdt_pkg::KEY_READ} :
    rd_status ? status_word :
    rd_count ? 32'(cnt) : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= wdt_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_mapped ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  // no history exists for $past at the very first edge
  logic past_ok;
  always_ff @(posedge aclk) begin
    past_ok <= 1'b1;
  end

  logic key_rd_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_rd_q <= 1'b0;
    end else if (ar_take) begin
      key_rd_q <= rd_key;
    end
  end

  AST_RESET_VALUE: assert property (@(posedge aclk)
    past_ok && !$past(aresetn) |-> (mode_reg == 8'h67 && !mode_written))
    else $error("mode register not at reset value");

  AST_DEFAULT_RUN: assert property (@(posedge aclk)
    !$past(aresetn) && aresetn |-> running && !nmi_sel)
    else $error("watchdog not running in reset mode after reset");

  AST_WRITE_ONCE: assert property (@(posedge aclk)
    disable iff (!aresetn) mode_we && mode_written |=> $stable(mode_reg))
    else $error("mode register changed by a later write");

  AST_SECOND_WRITE: assert property (@(posedge aclk)
    disable iff (!aresetn) mode_we && mode_written |=>
    (overflow_reset_out || overflow_nmi_request || cpu_clk_switch_req)
    && cnt == '0)
    else $error("second mode write did not force overflow");

  AST_NMI_ROUTE: assert property (@(posedge aclk)
    disable iff (!aresetn) timer_ovf && nmi_sel |=>
    overflow_nmi_request && !overflow_reset_out)
    else $error("nmi mode overflow not routed to nmi");

  AST_RST_ROUTE: assert property (@(posedge aclk)
    disable iff (!aresetn) ovf_evt && !nmi_sel && !osc_stab_active |=>
    overflow_reset_out && !overflow_nmi_request)
    else $error("reset mode overflow not routed to reset");

  AST_STOPPED: assert property (@(posedge aclk)
    disable iff (!aresetn) mode_reg[6:5] == 2'b00 && !cnt_clear |=>
    $stable(cnt))
    else $error("counter moved in stop mode");

  AST_KEY_CLEAR: assert property (@(posedge aclk)
    disable iff (!aresetn) key_ok |=> cnt == '0 ##1 !overflow_reset_out)
    else $error("key write did not clear counter");

  AST_BAD_KEY: assert property (@(posedge aclk)
    disable iff (!aresetn) key_we && wr_data[7:0] != 8'hac |=>
    (overflow_reset_out || overflow_nmi_request || cpu_clk_switch_req))
    else $error("wrong key did not force overflow");

  AST_KEY_READ: assert property (@(posedge aclk)
    disable iff (!aresetn) s_axi_rvalid && key_rd_q |->
    s_axi_rdata == 32'h0000_009a)
    else $error("key register read value wrong");

  AST_OSC_FREEZE: assert property (@(posedge aclk)
    disable iff (!aresetn) src_now == wdt_pkg::SRC_OSC &&
    internal_osc_stop && !cnt_clear |=> $stable(cnt))
    else $error("counter advanced with oscillator halted");

  AST_STAB_SWITCH: assert property (@(posedge aclk)
    disable iff (!aresetn) ovf_evt && !nmi_sel && osc_stab_active |=>
    cpu_clk_switch_req && !overflow_reset_out)
    else $error("overflow in stabilisation reset the chip");

  AST_BRESP_TIME: assert property (@(posedge aclk)
    disable iff (!aresetn) aw_take && w_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");

  COV_NMI: cover property (@(posedge aclk) disable iff (!aresetn)
    overflow_nmi_request);
  COV_RESET: cover property (@(posedge aclk) disable iff (!aresetn)
    timer_ovf && !nmi_sel);
  COV_KEY: cover property (@(posedge aclk) disable iff (!aresetn)
    key_ok ##[1:100] key_ok);
  COV_SECOND: cover property (@(posedge aclk) disable iff (!aresetn)
    first_mode_we ##[1:50] (mode_we && mode_written));

endmodule : default_start_watchdog
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the default-start watchdog over AXI4-Lite
// assumes wdt_pkg and the design files are compiled ahead of this one
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk, aresetn;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic osc_tick, main_tick, sub_tick, osc_stop, stab;
  logic rst_out, nmi_out, sw_out;
  int error_cnt, checks, cyc, n_rst, n_nmi, n_sw, e_rst, e_nmi, e_sw;

  default_start_watchdog u_default_start_watchdog (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .osc_tick(osc_tick), .main_tick(main_tick), .sub_tick(sub_tick),
    .internal_osc_stop(osc_stop), .osc_stab_active(stab),
    .overflow_reset_out(rst_out), .overflow_nmi_request(nmi_out),
    .cpu_clk_switch_req(sw_out)
  );

  initial begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end

  // pulses are one cycle wide, so count them at every edge
  always @(posedge aclk) begin
    if (rst_out === 1'h1) n_rst++;
    if (nmi_out === 1'h1) n_nmi++;
    if (sw_out === 1'h1) n_sw++;
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      $display("ERROR %0t run did not finish in time", $time);
      results();
    end
  end

  task results;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 100);
    chk({31'h0, n < 100}, 32'h1, "write answered");
    chk({30'h0, bresp}, {30'h0, er}, "bresp");
  endtask : wr

  task rdr(input logic [31:0] a, input logic [1:0] er, output logic [31:0] v);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 100);
    v = rdata;
    chk({31'h0, n < 100}, 32'h1, "read answered");
    chk({30'h0, rresp}, {30'h0, er}, "rresp");
  endtask : rdr

  task rchk(input logic [31:0] a, input logic [31:0] exp, input string what);
    rdr(a, wdt_pkg::RESP_OKAY, rd);
    chk(rd, exp, what);
  endtask : rchk

  // which: 0 internal oscillator, 1 main clock, 2 subclock
  task ticks(input int which, input int n);
    repeat (n) begin
      osc_tick <= (which == 0);
      main_tick <= (which == 1);
      sub_tick <= (which == 2);
      @(posedge aclk);
      osc_tick <= 1'h0;
      main_tick <= 1'h0;
      sub_tick <= 1'h0;
      @(posedge aclk);
    end
  endtask : ticks

  task pulses;
    repeat (3) @(posedge aclk);
    chk(n_rst, e_rst, "reset pulses");
    chk(n_nmi, e_nmi, "nmi pulses");
    chk(n_sw, e_sw, "clock switch pulses");
  endtask : pulses

  task do_reset;
    aresetn <= 1'h0;
    osc_stop <= 1'h0;
    stab <= 1'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
  endtask : do_reset

  task t_defaults;
    rchk(wdt_pkg::ADDR_MODE, 32'h67, "mode reset");
    rchk(wdt_pkg::ADDR_KEY, 32'h9a, "key reset");
    rchk(wdt_pkg::ADDR_STATUS, 32'h2, "status default");
    ticks(0, 5);
    rchk(wdt_pkg::ADDR_COUNT, 32'h5, "self start");
    osc_stop <= 1'h1;
    ticks(0, 3);
    rchk(wdt_pkg::ADDR_COUNT, 32'h5, "halted osc");
    osc_stop <= 1'h0;
    wr(wdt_pkg::ADDR_KEY, 8'hac, wdt_pkg::RESP_OKAY);
    rchk(wdt_pkg::ADDR_COUNT, 32'h0, "restart");
    rchk(wdt_pkg::ADDR_KEY, 32'h9a, "key after ac");
    pulses();
    rdr(32'h0fff_f800, wdt_pkg::RESP_SLVERR, rd);
  endtask : t_defaults

  task t_forced;
    wr(wdt_pkg::ADDR_KEY, 8'h55, wdt_pkg::RESP_OKAY);
    e_rst++;
    pulses();
    wr(wdt_pkg::ADDR_BITOP, 8'h01, wdt_pkg::RESP_OKAY);
    e_rst++;
    pulses();
    stab <= 1'h1;
    wr(wdt_pkg::ADDR_KEY, 8'h00, wdt_pkg::RESP_OKAY);
    e_sw++;
    stab <= 1'h0;
    pulses();
  endtask : t_forced

  task t_sub;
    do_reset();
    ticks(0, 4);
    wr(wdt_pkg::ADDR_MODE, 8'hd0, wdt_pkg::RESP_OKAY);
    rchk(wdt_pkg::ADDR_MODE, 32'h50, "first mode write");
    rchk(wdt_pkg::ADDR_STATUS, 32'h3, "status written");
    rchk(wdt_pkg::ADDR_COUNT, 32'h0, "write restarts");
    ticks(0, 3);
    rchk(wdt_pkg::ADDR_COUNT, 32'h0, "osc ignored on sub");
    ticks(2, 511);
    pulses();
    ticks(2, 1);
    e_rst++;
    pulses();
    ticks(2, 5);
    wr(wdt_pkg::ADDR_MODE, 8'h20, wdt_pkg::RESP_OKAY);
    e_rst++;
    pulses();
    rchk(wdt_pkg::ADDR_MODE, 32'h50, "second write ignored");
    rchk(wdt_pkg::ADDR_COUNT, 32'h0, "second write clears");
  endtask : t_sub

  task t_nmi;
    do_reset();
    wr(wdt_pkg::ADDR_MODE, 8'h20, wdt_pkg::RESP_OKAY);
    rchk(wdt_pkg::ADDR_STATUS, 32'hb, "status nmi mode");
    ticks(0, 4095);
    pulses();
    ticks(0, 1);
    e_nmi++;
    pulses();
  endtask : t_nmi

  task t_src_stop;
    do_reset();
    wr(wdt_pkg::ADDR_MODE, 8'h48, wdt_pkg::RESP_OKAY);
    ticks(1, 3);
    ticks(2, 2);
    ticks(0, 2);
    rchk(wdt_pkg::ADDR_COUNT, 32'h3, "main source");
    do_reset();
    wr(wdt_pkg::ADDR_MODE, 8'h58, wdt_pkg::RESP_OKAY);
    ticks(2, 2);
    ticks(1, 3);
    rchk(wdt_pkg::ADDR_COUNT, 32'h2, "sub source, 1x");
    do_reset();
    wr(wdt_pkg::ADDR_KEY, 8'hac, wdt_pkg::RESP_OKAY);
    wr(wdt_pkg::ADDR_MODE, 8'h00, wdt_pkg::RESP_OKAY);
    ticks(0, 10);
    rchk(wdt_pkg::ADDR_COUNT, 32'h0, "stopped");
    pulses();
  endtask : t_src_stop

  initial begin
    {awaddr, wdata, araddr, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {osc_tick, main_tick, sub_tick} = '0;
    do_reset();
    t_defaults();
    t_forced();
    t_sub();
    t_nmi();
    t_src_stop();
    results();
  end
endmodule : tb
`default_nettype wire
